/* File: verilog/temp_sensor_conversion_regs.sv */
/*
   Conversion control and register file of a 12-bit temperature sensor.
   Register accesses arrive from two-wire framing logic on LINK_CLK_I;
   conversion and warning logic run on CORE_CLK_I. Words cross both ways
   by toggle handshakes. TEMP_CODE_I comes from the converter front end.
*/
// Operation
// - Continuous conversions, each result replaces the previous temperature value.
// - rate_field selects 37, 18, 9 or 4 Hz conversion rate.
// - Conversion lasts 27 ms; slower rates idle afterwards for a rate delay.
// - At rate 0 the next conversion starts immediately, no idle delay.
// - After reset or general call a conversion starts at once.
// - power_down_ctl set finishes current conversion, then shuts down.
// - power_down_ctl clear means continuous conversion.
// - Rising shutdown edge clears warning output and fault counter.
// - Rewriting power_down_ctl while shut down clears nothing.
// - single_shot_trigger in shutdown runs one conversion, then shuts down again.
// - single_shot_trigger always reads back as zero.
// - Write-only 8-bit selector, reset 00h, two low bits pick register.
// - Selector 0 temperature, 1 configuration, 2 lower_limit, 3 upper_limit.
// - Temperature in bits 15..4, low nibble reads zero, resets 0000h.
// - Configuration field layout; low byte reads FFh; resets 00FFh.
// - fault_count_select needs 1, 2, 4 or 6 consecutive faults.
// - warning_sense 0 active-low warning, 1 active-high.
// - thermostat_style 0 comparator style, 1 interrupt style.
// - lower_limit 12-bit value in bits 15..4, resets 4B00h.
// - upper_limit 12-bit value in bits 15..4, resets 5000h.
// - General-call reset returns all registers to power-up values.
`timescale 1ns/1ps
`default_nettype none

module temp_sensor_conversion_regs
#(
   parameter int unsigned CONV_CYCLES  = temp_sensor_pkg::CONV_CYCLES,
   parameter int unsigned IDLE1_CYCLES = temp_sensor_pkg::IDLE1_CYCLES,
   parameter int unsigned IDLE2_CYCLES = temp_sensor_pkg::IDLE2_CYCLES,
   parameter int unsigned IDLE3_CYCLES = temp_sensor_pkg::IDLE3_CYCLES
)
(
   input  wire logic        CORE_CLK_I,
   input  wire logic        RESETN_I,
   input  wire logic        CE_I,
   input  wire logic [11:0] TEMP_CODE_I,
   input  wire logic        LINK_CLK_I,
   input  wire logic        PTR_WR_I,
   input  wire logic [7:0]  PTR_DATA_I,
   input  wire logic        REG_WR_I,
   input  wire logic [15:0] REG_WDATA_I,
   input  wire logic        REG_RD_I,
   input  wire logic        GEN_RESET_I,
   output logic             LINK_BUSY_O,
   output logic [15:0]      RDATA_O,
   output logic             ALERT_O,
   output logic             CONV_ACTIVE_O
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [2:0] fault_need(input logic [1:0] sel);
      case (sel)
         2'h0:    fault_need = temp_sensor_pkg::FAULTS_Q0;
         2'h1:    fault_need = temp_sensor_pkg::FAULTS_Q1;
         2'h2:    fault_need = temp_sensor_pkg::FAULTS_Q2;
         default: fault_need = temp_sensor_pkg::FAULTS_Q3;
      endcase
   endfunction

   function automatic logic [15:0] value_word(input logic [11:0] v);
      value_word = {v, temp_sensor_pkg::RESERVED_NIBBLE};
   endfunction

   localparam logic [22:0] conv_last  = 23'(CONV_CYCLES - 1);
   localparam logic [22:0] idle1_last = 23'(IDLE1_CYCLES - 1);
   localparam logic [22:0] idle2_last = 23'(IDLE2_CYCLES - 1);
   localparam logic [22:0] idle3_last = 23'(IDLE3_CYCLES - 1);

   // ----------------------------------------------------------------
   // Link domain: selector and request capture
   // ----------------------------------------------------------------
   logic [7:0]  selector_reg;
   logic [2:0]  req_kind_reg;
   logic [1:0]  req_sel_reg;
   logic [15:0] req_data_reg;
   logic        req_tgl_reg;
   logic        ack_meta_reg;
   logic        ack_sync_reg;
   logic        snap_meta_reg;
   logic        snap_sync_reg;
   logic        snap_ack_reg;
   logic [63:0] shadow_reg;
   logic        link_busy;
   logic        ack_tgl_reg;
   logic        snap_tgl_reg;
   logic [63:0] snap_data_reg;

   assign link_busy   = req_tgl_reg != ack_sync_reg;
   assign LINK_BUSY_O = link_busy;

   always_ff @(posedge LINK_CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         selector_reg <= temp_sensor_pkg::SELECTOR_RESET;
      end
      else if (GEN_RESET_I && !link_busy)
      begin
         selector_reg <= temp_sensor_pkg::SELECTOR_RESET;
      end
      else if (PTR_WR_I)
      begin
         selector_reg <= PTR_DATA_I;
      end
   end

   always_ff @(posedge LINK_CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         req_kind_reg <= 3'h0;
         req_sel_reg  <= 2'h0;
         req_data_reg <= 16'h0000;
         req_tgl_reg  <= 1'b0;
      end
      else if (!link_busy && (REG_WR_I || REG_RD_I || GEN_RESET_I))
      begin
         req_kind_reg <= {GEN_RESET_I, REG_WR_I, REG_RD_I};
         req_sel_reg  <= selector_reg[1:0];
         req_data_reg <= REG_WDATA_I;
         req_tgl_reg  <= ~req_tgl_reg;
      end
   end

   always_ff @(posedge LINK_CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         ack_meta_reg  <= 1'b0;
         ack_sync_reg  <= 1'b0;
         snap_meta_reg <= 1'b0;
         snap_sync_reg <= 1'b0;
      end
      else
      begin
         ack_meta_reg  <= ack_tgl_reg;
         ack_sync_reg  <= ack_meta_reg;
         snap_meta_reg <= snap_tgl_reg;
         snap_sync_reg <= snap_meta_reg;
      end
   end

   // Shadow copy of all readable words, taken whole from the core
   always_ff @(posedge LINK_CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         shadow_reg   <= {temp_sensor_pkg::TEMPERATURE_RESET, temp_sensor_pkg::CONFIG_RESET,
                          temp_sensor_pkg::LOWER_RESET, temp_sensor_pkg::UPPER_RESET};
         snap_ack_reg <= 1'b0;
      end
      else if (snap_sync_reg != snap_ack_reg)
      begin
         shadow_reg   <= snap_data_reg;
         snap_ack_reg <= snap_sync_reg;
      end
   end

   always_ff @(posedge LINK_CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         RDATA_O <= temp_sensor_pkg::TEMPERATURE_RESET;
      end
      else
      begin
         case (selector_reg[1:0])
            temp_sensor_pkg::SEL_TEMPERATURE: RDATA_O <= shadow_reg[63:48];
            temp_sensor_pkg::SEL_CONFIG:      RDATA_O <= shadow_reg[47:32];
            temp_sensor_pkg::SEL_LOWER:       RDATA_O <= shadow_reg[31:16];
            default:                          RDATA_O <= shadow_reg[15:0];
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Core domain: crossings
   // ----------------------------------------------------------------
   logic        req_meta_reg;
   logic        req_sync_reg;
   logic        sack_meta_reg;
   logic        sack_sync_reg;
   logic [11:0] code_meta_reg;
   logic [11:0] code_sync_reg;
   logic        new_req;
   logic        gcall;
   logic        wr_hit;
   logic        rd_hit;
   logic        cfg_wr;

   assign new_req = req_sync_reg != ack_tgl_reg;
   assign gcall   = new_req && req_kind_reg[temp_sensor_pkg::KIND_GCALL];
   assign wr_hit  = new_req && req_kind_reg[temp_sensor_pkg::KIND_WRITE] && !gcall;
   assign rd_hit  = new_req && req_kind_reg[temp_sensor_pkg::KIND_READ] && !gcall;
   assign cfg_wr  = wr_hit && (req_sel_reg == temp_sensor_pkg::SEL_CONFIG);

   always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         req_meta_reg  <= 1'b0;
         req_sync_reg  <= 1'b0;
         ack_tgl_reg   <= 1'b0;
         sack_meta_reg <= 1'b0;
         sack_sync_reg <= 1'b0;
         code_meta_reg <= 12'h000;
         code_sync_reg <= 12'h000;
      end
      else if (CE_I)
      begin
         req_meta_reg  <= req_tgl_reg;
         req_sync_reg  <= req_meta_reg;
         sack_meta_reg <= snap_ack_reg;
         sack_sync_reg <= sack_meta_reg;
         code_meta_reg <= TEMP_CODE_I;
         code_sync_reg <= code_meta_reg;
         if (new_req)
         begin
            ack_tgl_reg <= req_sync_reg;
         end
      end
   end

   // ----------------------------------------------------------------
   // Core domain: registers
   // ----------------------------------------------------------------
   logic [11:0] temp_reg;
   logic [1:0]  rate_reg;
   logic [1:0]  fault_sel_reg;
   logic        sense_reg;
   logic        style_reg;
   logic        pdown_reg;
   logic [11:0] lower_reg;
   logic [11:0] upper_reg;
   logic        conv_done;
   logic        pdown_rise;
   logic        oneshot_go;
   temp_sensor_pkg::conv_state_e state_reg;

   assign pdown_rise = cfg_wr && req_data_reg[temp_sensor_pkg::CFG_PDOWN_BIT] && !pdown_reg;
   assign oneshot_go = cfg_wr && req_data_reg[temp_sensor_pkg::CFG_ONESHOT_BIT]
                       && (state_reg == temp_sensor_pkg::ST_SHUT);

   always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         rate_reg      <= temp_sensor_pkg::CONFIG_RESET[14:13];
         fault_sel_reg <= temp_sensor_pkg::CONFIG_RESET[12:11];
         sense_reg     <= temp_sensor_pkg::CONFIG_RESET[10];
         style_reg     <= temp_sensor_pkg::CONFIG_RESET[9];
         pdown_reg     <= temp_sensor_pkg::CONFIG_RESET[8];
         lower_reg     <= temp_sensor_pkg::LOWER_RESET[15:4];
         upper_reg     <= temp_sensor_pkg::UPPER_RESET[15:4];
      end
      else if (CE_I)
      begin
         if (gcall)
         begin
            rate_reg      <= temp_sensor_pkg::CONFIG_RESET[14:13];
            fault_sel_reg <= temp_sensor_pkg::CONFIG_RESET[12:11];
            sense_reg     <= temp_sensor_pkg::CONFIG_RESET[10];
            style_reg     <= temp_sensor_pkg::CONFIG_RESET[9];
            pdown_reg     <= temp_sensor_pkg::CONFIG_RESET[8];
            lower_reg     <= temp_sensor_pkg::LOWER_RESET[15:4];
            upper_reg     <= temp_sensor_pkg::UPPER_RESET[15:4];
         end
         else if (cfg_wr)
         begin
            rate_reg      <= req_data_reg[14:13];
            fault_sel_reg <= req_data_reg[12:11];
            sense_reg     <= req_data_reg[temp_sensor_pkg::CFG_SENSE_BIT];
            style_reg     <= req_data_reg[temp_sensor_pkg::CFG_STYLE_BIT];
            pdown_reg     <= req_data_reg[temp_sensor_pkg::CFG_PDOWN_BIT];
         end
         else if (wr_hit && req_sel_reg == temp_sensor_pkg::SEL_LOWER)
         begin
            lower_reg <= req_data_reg[15:4];
         end
         else if (wr_hit && req_sel_reg == temp_sensor_pkg::SEL_UPPER)
         begin
            upper_reg <= req_data_reg[15:4];
         end
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         temp_reg <= temp_sensor_pkg::TEMPERATURE_RESET[15:4];
      end
      else if (CE_I)
      begin
         if (gcall)
         begin
            temp_reg <= temp_sensor_pkg::TEMPERATURE_RESET[15:4];
         end
         else if (conv_done)
         begin
            temp_reg <= code_sync_reg;
         end
      end
   end

   // ----------------------------------------------------------------
   // Core domain: conversion sequencing
   // ----------------------------------------------------------------
   logic [22:0] cnt_reg;
   logic [22:0] idle_last;

   always_comb
   begin
      case (rate_reg)
         2'h1:    idle_last = idle1_last;
         2'h2:    idle_last = idle2_last;
         default: idle_last = idle3_last;
      endcase
   end

   assign conv_done     = (state_reg == temp_sensor_pkg::ST_CONV) && (cnt_reg == conv_last) && !gcall;
   assign CONV_ACTIVE_O = state_reg == temp_sensor_pkg::ST_CONV;

   always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         state_reg <= temp_sensor_pkg::ST_CONV;
         cnt_reg   <= 23'h000000;
      end
      else if (CE_I)
      begin
         if (gcall)
         begin
            state_reg <= temp_sensor_pkg::ST_CONV;
            cnt_reg   <= 23'h000000;
         end
         else
         begin
            case (state_reg)
               temp_sensor_pkg::ST_CONV:
               begin
                  if (conv_done)
                  begin
                     cnt_reg <= 23'h000000;
                     if (pdown_reg)
                     begin
                        state_reg <= temp_sensor_pkg::ST_SHUT;
                     end
                     else if (rate_reg == 2'h0)
                     begin
                        state_reg <= temp_sensor_pkg::ST_CONV;
                     end
                     else
                     begin
                        state_reg <= temp_sensor_pkg::ST_WAIT;
                     end
                  end
                  else
                  begin
                     cnt_reg <= cnt_reg + 23'h000001;
                  end
               end
               temp_sensor_pkg::ST_WAIT:
               begin
                  if (pdown_reg)
                  begin
                     state_reg <= temp_sensor_pkg::ST_SHUT;
                     cnt_reg   <= 23'h000000;
                  end
                  else if (cnt_reg >= idle_last)
                  begin
                     state_reg <= temp_sensor_pkg::ST_CONV;
                     cnt_reg   <= 23'h000000;
                  end
                  else
                  begin
                     cnt_reg <= cnt_reg + 23'h000001;
                  end
               end
               temp_sensor_pkg::ST_SHUT:
               begin
                  cnt_reg <= 23'h000000;
                  if (!pdown_reg || oneshot_go)
                  begin
                     state_reg <= temp_sensor_pkg::ST_CONV;
                  end
               end
               default:
               begin
                  state_reg <= temp_sensor_pkg::ST_CONV;
                  cnt_reg   <= 23'h000000;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Core domain: fault queue and warning output
   // ----------------------------------------------------------------
   logic [2:0] fault_cnt_reg;
   logic       dir_reg;
   logic       int_reg;
   logic       fault_hit;
   logic       queue_full;
   logic       warn_active;

   assign fault_hit   = dir_reg ? ($signed(code_sync_reg) < $signed(lower_reg))
                                : ($signed(code_sync_reg) >= $signed(upper_reg));
   assign queue_full  = (fault_cnt_reg + 3'h1) >= fault_need(fault_sel_reg);
   assign warn_active = style_reg ? int_reg : dir_reg;

   always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         fault_cnt_reg <= 3'h0;
         dir_reg       <= 1'b0;
         int_reg       <= 1'b0;
      end
      else if (CE_I)
      begin
         if (gcall || pdown_rise)
         begin
            fault_cnt_reg <= 3'h0;
            dir_reg       <= 1'b0;
            int_reg       <= 1'b0;
         end
         else
         begin
            if (rd_hit)
            begin
               int_reg <= 1'b0;
            end
            if (conv_done && fault_hit && queue_full)
            begin
               fault_cnt_reg <= 3'h0;
               dir_reg       <= ~dir_reg;
               int_reg       <= 1'b1;
            end
            else if (conv_done && fault_hit)
            begin
               fault_cnt_reg <= fault_cnt_reg + 3'h1;
            end
            else if (conv_done)
            begin
               fault_cnt_reg <= 3'h0;
            end
         end
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         ALERT_O <= 1'b1;
      end
      else if (CE_I)
      begin
         ALERT_O <= sense_reg ? warn_active : ~warn_active;
      end
   end

   // ----------------------------------------------------------------
   // Core domain: snapshot of readable words toward the link
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         snap_tgl_reg  <= 1'b0;
         snap_data_reg <= {temp_sensor_pkg::TEMPERATURE_RESET, temp_sensor_pkg::CONFIG_RESET,
                           temp_sensor_pkg::LOWER_RESET, temp_sensor_pkg::UPPER_RESET};
      end
      else if (CE_I && (sack_sync_reg == snap_tgl_reg))
      begin
         snap_tgl_reg  <= ~snap_tgl_reg;
         snap_data_reg <= {value_word(temp_reg),
                           1'b0, rate_reg, fault_sel_reg, sense_reg, style_reg, pdown_reg,
                           temp_sensor_pkg::CFG_LOW_BYTE,
                           value_word(lower_reg), value_word(upper_reg)};
      end
   end

endmodule

`default_nettype wire

/* File: shared/temp_sensor_pkg.sv */
/*
   Constants, field layouts, reset values and state encodings of the
   temperature sensor conversion and register block.
   Assumes a 25 MHz core clock; timing counts are derived from it.
*/
package temp_sensor_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CORE_CLK_HZ  = 25_000_000;
   localparam int unsigned CONV_TIME_MS = 27;
   localparam int unsigned CONV_CYCLES  = CORE_CLK_HZ / 1000 * CONV_TIME_MS;
   localparam int unsigned RATE1_HZ     = 18;
   localparam int unsigned RATE2_HZ     = 9;
   localparam int unsigned RATE3_HZ     = 4;
   localparam int unsigned IDLE1_CYCLES = CORE_CLK_HZ / RATE1_HZ - CONV_CYCLES;
   localparam int unsigned IDLE2_CYCLES = CORE_CLK_HZ / RATE2_HZ - CONV_CYCLES;
   localparam int unsigned IDLE3_CYCLES = CORE_CLK_HZ / RATE3_HZ - CONV_CYCLES;
   localparam int unsigned CNT_W        = 23;

   // ----------------------------------------------------------------
   // Register selector values
   // ----------------------------------------------------------------
   localparam logic [1:0] SEL_TEMPERATURE = 2'h0;
   localparam logic [1:0] SEL_CONFIG      = 2'h1;
   localparam logic [1:0] SEL_LOWER       = 2'h2;
   localparam logic [1:0] SEL_UPPER       = 2'h3;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int unsigned CFG_ONESHOT_BIT = 15;
   localparam int unsigned CFG_RATE_LSB    = 13;
   localparam int unsigned CFG_FAULT_LSB   = 11;
   localparam int unsigned CFG_SENSE_BIT   = 10;
   localparam int unsigned CFG_STYLE_BIT   = 9;
   localparam int unsigned CFG_PDOWN_BIT   = 8;
   localparam int unsigned VALUE_LSB       = 4;
   localparam logic [7:0]  CFG_LOW_BYTE    = 8'hFF;
   localparam logic [3:0]  RESERVED_NIBBLE = 4'h0;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0]  SELECTOR_RESET    = 8'h00;
   localparam logic [15:0] TEMPERATURE_RESET = 16'h0000;
   localparam logic [15:0] CONFIG_RESET      = 16'h00FF;
   localparam logic [15:0] LOWER_RESET       = 16'h4B00;
   localparam logic [15:0] UPPER_RESET       = 16'h5000;

   // ----------------------------------------------------------------
   // Fault queue depths
   // ----------------------------------------------------------------
   localparam logic [2:0] FAULTS_Q0 = 3'h1;
   localparam logic [2:0] FAULTS_Q1 = 3'h2;
   localparam logic [2:0] FAULTS_Q2 = 3'h4;
   localparam logic [2:0] FAULTS_Q3 = 3'h6;

   // ----------------------------------------------------------------
   // Request kinds and conversion states
   // ----------------------------------------------------------------
   localparam int unsigned KIND_READ  = 0;
   localparam int unsigned KIND_WRITE = 1;
   localparam int unsigned KIND_GCALL = 2;

   typedef enum logic [2:0]
   {
      ST_CONV = 3'b001,
      ST_WAIT = 3'b010,
      ST_SHUT = 3'b100
   } conv_state_e;

endpackage

/* File: tb/temp_sensor_conversion_regs_asserts.sv */
/* Checker of the conversion and register block.
   Assumes it is bound to the block's top ports. */
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_conversion_regs_asserts
(
   input  wire logic        CORE_CLK_I,
   input  wire logic        RESETN_I,
   input  wire logic        LINK_CLK_I,
   input  wire logic        PTR_WR_I,
   input  wire logic [7:0]  PTR_DATA_I,
   input  wire logic        REG_WR_I,
   input  wire logic        REG_RD_I,
   input  wire logic        GEN_RESET_I,
   input  wire logic        LINK_BUSY_O,
   input  wire logic [15:0] RDATA_O,
   input  wire logic        ALERT_O,
   input  wire logic        CONV_ACTIVE_O
);
   a_busy_take: assert property (@(posedge LINK_CLK_I) disable iff (!RESETN_I)
      (REG_WR_I || REG_RD_I || GEN_RESET_I) && !LINK_BUSY_O |=> LINK_BUSY_O) else $error("busy not raised");
   a_busy_free: assert property (@(posedge LINK_CLK_I) disable iff (!RESETN_I)
      $rose(LINK_BUSY_O) |-> ##[1:30] !LINK_BUSY_O) else $error("busy stuck");
   a_conv_len: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
      $rose(CONV_ACTIVE_O) |-> CONV_ACTIVE_O[*8]) else $error("conversion cut short");
   a_cfg_read: assert property (@(posedge LINK_CLK_I) disable iff (!RESETN_I)
      PTR_WR_I && PTR_DATA_I[1:0] == 2'h1 |-> ##2 RDATA_O[7:0] == 8'hFF && !RDATA_O[15])
      else $error("config word bad");
   a_value_read: assert property (@(posedge LINK_CLK_I) disable iff (!RESETN_I)
      PTR_WR_I && PTR_DATA_I[1:0] != 2'h1 |-> ##2 RDATA_O[3:0] == 4'h0) else $error("low nibble set");
   a_alert_rst: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
      $rose(RESETN_I) |-> ALERT_O) else $error("alert active at reset");
   a_gen_clear: assert property (@(posedge LINK_CLK_I) disable iff (!RESETN_I)
      GEN_RESET_I && !LINK_BUSY_O |-> ##[2:50] RDATA_O == 16'h0000) else $error("general call no reset");
   a_rdata_nib: assert property (@(posedge LINK_CLK_I) disable iff (!RESETN_I)
      RDATA_O[3:0] == 4'h0 || RDATA_O[3:0] == 4'hF) else $error("bad low nibble");
endmodule
bind temp_sensor_conversion_regs temp_sensor_conversion_regs_asserts temp_sensor_conversion_regs_asserts_i (.*);
`default_nettype wire

/* File: tb/link_master.sv */
/* Two-wire master model issuing link requests.
   Assumes the block's link clock and busy flag. */
`timescale 1ns/1ps
`default_nettype none
module link_master
(
   input  wire logic        clk_i,
   input  wire logic        busy_i,
   output logic             ptr_wr_o,
   output logic [7:0]       ptr_o,
   output logic             wr_o,
   output logic [15:0]      wdata_o,
   output logic             rd_o,
   output logic             gen_o
);
   initial {ptr_wr_o, ptr_o, wr_o, wdata_o, rd_o, gen_o} = '0;
   task automatic ptr(input logic [7:0] b);
      @(negedge clk_i);
      {ptr_wr_o, ptr_o} = {1'b1, b};
      @(negedge clk_i);
      {ptr_wr_o, ptr_o} = {1'b0, ~b};
   endtask
   // Kind 1 write, 2 read notice, 3 general call
   task automatic req(input logic [1:0] k, input logic [15:0] d);
      @(negedge clk_i);
      while (busy_i) @(negedge clk_i);
      {wr_o, rd_o, gen_o} = {k == 2'h1, k == 2'h2, k == 2'h3};
      wdata_o = d;
      @(negedge clk_i);
      {wr_o, rd_o, gen_o} = 3'h0;
      wdata_o = ~d;
      @(negedge clk_i);
      while (busy_i) @(negedge clk_i);
   endtask
endmodule
`default_nettype wire

/* File: tb/temp_sensor_conversion_regs_tb.sv */
/* Register and conversion tests of the sensor block.
   Assumes shortened timing parameters. */
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_conversion_regs_tb;
   logic        core_clk = 0, link_clk = 0, resetn = 0, ce = 1;
   logic [11:0] code = 12'h123;
   logic        ptr_wr, wr, rd, gen, busy, alert, active;
   logic [7:0]  ptr;
   logic [15:0] wdata, rdata;
   int          bad_count = 0, compares = 0, n;
   int          idle[4] = '{0, 10, 30, 60};
   always #20 core_clk = ~core_clk;
   always #7.5 link_clk = ~link_clk;
   temp_sensor_conversion_regs #(.CONV_CYCLES(20), .IDLE1_CYCLES(10), .IDLE2_CYCLES(30), .IDLE3_CYCLES(60))
      temp_sensor_conversion_regs_i (.CORE_CLK_I(core_clk), .RESETN_I(resetn), .CE_I(ce), .TEMP_CODE_I(code),
      .LINK_CLK_I(link_clk), .PTR_WR_I(ptr_wr), .PTR_DATA_I(ptr), .REG_WR_I(wr), .REG_WDATA_I(wdata),
      .REG_RD_I(rd), .GEN_RESET_I(gen), .LINK_BUSY_O(busy), .RDATA_O(rdata), .ALERT_O(alert),
      .CONV_ACTIVE_O(active));
   link_master link_master_i (.clk_i(link_clk), .busy_i(busy), .ptr_wr_o(ptr_wr), .ptr_o(ptr), .wr_o(wr),
      .wdata_o(wdata), .rd_o(rd), .gen_o(gen));
   task automatic chk(input string w, input logic [15:0] e, input logic [15:0] s);
      compares++;
      if (s !== e)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic rdr(input logic [7:0] p, input logic [15:0] e);
      link_master_i.ptr(p);
      repeat (20) @(negedge link_clk);
      chk("register", e, rdata);
      link_master_i.req(2'h2, 16'h0000);
   endtask
   task automatic wrr(input logic [7:0] p, input logic [15:0] d);
      link_master_i.ptr(p);
      link_master_i.req(2'h1, d);
   endtask
   task automatic wrap_up;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      #2_000_000;
      bad_count++;
      wrap_up;
   end
   initial
   begin
      repeat (10) @(negedge core_clk);
      resetn = 1;
      repeat (4) @(negedge core_clk);
      rdr(8'h00, 16'h0000);
      repeat (30) @(negedge core_clk);
      rdr(8'h00, 16'h1230);
      rdr(8'h01, 16'h00FF);
      rdr(8'h02, 16'h4B00);
      rdr(8'h03, 16'h5000);
      wrr(8'h02, 16'hABCF);
      rdr(8'h02, 16'hABC0);
      wrr(8'h03, 16'h7FFF);
      rdr(8'hFF, 16'h7FF0);
      wrr(8'h00, 16'hFFFF);
      rdr(8'h00, 16'h1230);
      wrr(8'h01, 16'h9E00);
      rdr(8'hFD, 16'h1EFF);
      repeat (30) @(negedge core_clk);
      chk("alert", 16'h0000, {15'h0, alert});
      for (int r = 0; r < 4; r++)
      begin
         wrr(8'h01, {1'b0, r[1:0], 13'h0000});
         repeat (100) @(negedge core_clk);
         n = 0;
         repeat (20 + idle[r]) @(negedge core_clk) n += !active;
         chk("idle", idle[r][15:0], n[15:0]);
      end
      wrr(8'h01, 16'h0100);
      repeat (25) @(negedge core_clk);
      n = 0;
      repeat (100) @(negedge core_clk) n += active;
      chk("shutdown", 16'h0000, n[15:0]);
      code = 12'h456;
      wrr(8'h01, 16'h8100);
      @(negedge core_clk) ce = 0;
      repeat (40) @(negedge core_clk);
      chk("frozen", 16'h0001, {15'h0, active});
      ce = 1;
      repeat (40) @(negedge core_clk);
      chk("one shot", 16'h0000, {15'h0, active});
      rdr(8'h00, 16'h4560);
      rdr(8'h01, 16'h01FF);
      wrr(8'h03, 16'h4000);
      wrr(8'h01, 16'h0000);
      repeat (30) @(negedge core_clk);
      chk("alert", 16'h0000, {15'h0, alert});
      wrr(8'h03, 16'h7FFF);
      wrr(8'h01, 16'h0100);
      repeat (5) @(negedge core_clk);
      chk("alert", 16'h0001, {15'h0, alert});
      wrr(8'h03, 16'h4000);
      wrr(8'h01, 16'h8100);
      repeat (40) @(negedge core_clk);
      wrr(8'h01, 16'h0100);
      repeat (5) @(negedge core_clk);
      chk("alert", 16'h0000, {15'h0, alert});
      link_master_i.req(2'h3, 16'h0000);
      rdr(8'h00, 16'h0000);
      rdr(8'h01, 16'h00FF);
      rdr(8'h03, 16'h5000);
      wrap_up;
   end
endmodule
`default_nettype wire
